// [riu_pkg.sv]
// Purpose: Shared constants and types for the return instruction unit.
// Assumes: Byte addresses on a 32-bit APB bus, one aligned word per register.
// Notes: One clock edge is one quarter of an instruction cycle.
package riu_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int PC_W = 21;
    localparam int BANK_W = 4;

    // Register byte offsets.
    localparam logic [7:0] OFS_INSTR = 8'h00;
    localparam logic [7:0] OFS_CTRL = 8'h04;
    localparam logic [7:0] OFS_IRQ_EN = 8'h08;
    localparam logic [7:0] OFS_ACC = 8'h0C;
    localparam logic [7:0] OFS_FLAGS = 8'h10;
    localparam logic [7:0] OFS_BANK = 8'h14;
    localparam logic [7:0] OFS_ACC_SH = 8'h18;
    localparam logic [7:0] OFS_FLAGS_SH = 8'h1C;
    localparam logic [7:0] OFS_BANK_SH = 8'h20;
    localparam logic [7:0] OFS_TOP_OF_STACK = 8'h24;
    localparam logic [7:0] OFS_PC = 8'h28;
    localparam logic [7:0] OFS_PC_HIGH = 8'h2C;
    localparam logic [7:0] OFS_PC_UPPER = 8'h30;
    localparam logic [7:0] OFS_STAT = 8'h34;

    // Field positions.
    localparam int IE_HIGH_BIT = 7;
    localparam int IE_LOW_BIT = 6;
    localparam int CTRL_PRIO_BIT = 0;
    localparam int CTRL_LOWSVC_BIT = 1;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_BAD_BIT = 1;

    // Opcode patterns.
    localparam logic [14:0] IRQ_RET_PFX = 15'h0008;
    localparam logic [14:0] RETURN_PFX = 15'h0009;
    localparam logic [7:0] LIT_RET_PFX = 8'h0C;

    // Reset values.
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_INSTR = 16'h0000;
    localparam logic [PC_W-1:0] RST_PC = 21'h0;

    // Quarter phase sequencing.
    localparam logic [1:0] Q_FIRST = 2'h0;
    localparam logic [1:0] Q_LAST = 2'h3;

    typedef enum logic [1:0] {
        RIU_IDLE = 2'b00,
        RIU_EXEC = 2'b01,
        RIU_REFILL = 2'b11
    } riu_state_type;

endpackage : riu_pkg

// [riu_decode.sv]
// Purpose: Recognises the three return opcodes and splits out their fields.
// Assumes: The opcode is stable while it is decoded.
// Notes: Purely combinational.
module riu_decode (
    // Opcode in.
    input wire logic [15:0] opcode_i,
    // Decoded fields.
    output logic is_irq_ret_o,
    output logic is_return_o,
    output logic is_lit_ret_o,
    output logic shadow_o,
    output logic [7:0] literal_o
);

    always_comb begin
        // Fifteen fixed bits, the select bit last.
        is_irq_ret_o = (opcode_i[15:1] == riu_pkg::IRQ_RET_PFX);
        is_return_o = (opcode_i[15:1] == riu_pkg::RETURN_PFX);
        is_lit_ret_o = (opcode_i[15:8] == riu_pkg::LIT_RET_PFX);
        shadow_o = opcode_i[0] & (is_irq_ret_o | is_return_o);
        literal_o = opcode_i[7:0];
    end

endmodule : riu_decode

// [riu_qseq.sv]
// Purpose: Steps a return through two instruction cycles of four quarters.
// Assumes: Start is ignored while busy.
// Notes: The pop strobe falls in the last quarter of the first cycle.
module riu_qseq (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Control.
    input wire logic start_i,
    // Status.
    output logic busy_o,
    output logic pop_o,
    output logic [1:0] quarter_o
);

    riu_pkg::riu_state_type state_q;
    logic [1:0] quarter_q;

    // Advances the quarter count and the cycle state.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state_q <= riu_pkg::RIU_IDLE;
            quarter_q <= riu_pkg::Q_FIRST;
        end else begin
            case (state_q)
                riu_pkg::RIU_IDLE: begin
                    quarter_q <= riu_pkg::Q_FIRST;
                    if (start_i) begin
                        state_q <= riu_pkg::RIU_EXEC;
                    end
                end
                riu_pkg::RIU_EXEC: begin
                    quarter_q <= quarter_q + 2'h1;
                    if (quarter_q == riu_pkg::Q_LAST) begin
                        state_q <= riu_pkg::RIU_REFILL;
                    end
                end
                riu_pkg::RIU_REFILL: begin
                    quarter_q <= quarter_q + 2'h1;
                    if (quarter_q == riu_pkg::Q_LAST) begin
                        state_q <= riu_pkg::RIU_IDLE;
                    end
                end
                default: begin
                    state_q <= riu_pkg::RIU_IDLE;
                end
            endcase
        end
    end

    assign busy_o = (state_q != riu_pkg::RIU_IDLE);
    assign pop_o = (state_q == riu_pkg::RIU_EXEC) && (quarter_q == riu_pkg::Q_LAST);
    assign quarter_o = quarter_q;

endmodule : riu_qseq

// [riu_top.sv]
// Purpose: Executes the return instructions and holds the core state they touch.
// Assumes: APB slave with no wait states; a return opcode written to the instruction register while idle runs.
// Notes: Stack depth handling lives outside; this unit reads the top entry and pulses a pop.

// Functional notes
// - Decode interrupt return with trailing select bit.
// - Interrupt return pops stack into PC.
// - Interrupt return sets high or low enable.
// - Select one restores accumulator, flags, bank.
// - Select zero leaves those registers alone.
// - Only the two enable bits change.
// - Literal return loads literal into accumulator.
// - Literal return pops stack into PC.
// - PC high and upper latches stay unchanged.
// - Subroutine return loads PC, no enables.
module riu_top (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_n_i,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [riu_pkg::ADDR_W-1:0] paddr,
    input wire logic [riu_pkg::DATA_W-1:0] pwdata,
    output logic [riu_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Core side.
    output logic stack_pop_o,
    output logic [riu_pkg::PC_W-1:0] pc_o,
    output logic busy_o
);

    logic [15:0] instr_q;
    logic [1:0] ctrl_q;
    logic [7:0] irq_en_q;
    logic [7:0] acc_q;
    logic [7:0] flags_q;
    logic [riu_pkg::BANK_W-1:0] bank_q;
    logic [7:0] acc_sh_q;
    logic [7:0] flags_sh_q;
    logic [riu_pkg::BANK_W-1:0] bank_sh_q;
    logic [riu_pkg::PC_W-1:0] top_of_stack_q;
    logic [riu_pkg::PC_W-1:0] pc_q;
    logic [7:0] pc_high_q;
    logic [7:0] pc_upper_q;
    logic bad_q;
    logic [riu_pkg::DATA_W-1:0] rdata_q;

    logic is_irq_ret;
    logic is_return;
    logic is_lit_ret;
    logic shadow_sel;
    logic [7:0] literal;
    logic new_irq_ret;
    logic new_return;
    logic new_lit_ret;
    logic new_valid;
    logic busy;
    logic pop;
    logic [1:0] quarter;
    logic access;
    logic wr;
    logic mapped;
    logic start;
    logic wr_instr;
    logic restore;

    // Decodes the held opcode.
    riu_decode u_decode (
        .opcode_i(instr_q),
        .is_irq_ret_o(is_irq_ret),
        .is_return_o(is_return),
        .is_lit_ret_o(is_lit_ret),
        .shadow_o(shadow_sel),
        .literal_o(literal)
    );

    // Decodes the incoming write data to vet a new opcode.
    riu_decode u_vet (
        .opcode_i(pwdata[15:0]),
        .is_irq_ret_o(new_irq_ret),
        .is_return_o(new_return),
        .is_lit_ret_o(new_lit_ret),
        .shadow_o(),
        .literal_o()
    );

    // Sequences the two instruction cycles.
    riu_qseq u_seq (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .start_i(start),
        .busy_o(busy),
        .pop_o(pop),
        .quarter_o(quarter)
    );

    always_comb begin
        access = psel && penable;
        wr = access && pwrite;
        mapped = (paddr <= riu_pkg::OFS_STAT) && (paddr[1:0] == 2'b00);
        new_valid = new_irq_ret | new_return | new_lit_ret;
        wr_instr = wr && (paddr == riu_pkg::OFS_INSTR) && !busy;
        start = wr_instr && new_valid;
        restore = pop && shadow_sel && (is_irq_ret || is_return);
    end

    // Zero-wait APB handshake; a busy opcode write or an unmapped address errors.
    assign pready = 1'b1;
    assign pslverr = access && (!mapped || (pwrite && (paddr == riu_pkg::OFS_INSTR) && busy));

    // Holds the opcode taken from the bus.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            instr_q <= riu_pkg::RST_INSTR;
        end else if (wr_instr) begin
            instr_q <= pwdata[15:0];
        end
    end

    // Control bits: priority scheme and which level is being serviced.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ctrl_q <= 2'h0;
        end else if (wr && (paddr == riu_pkg::OFS_CTRL)) begin
            ctrl_q <= pwdata[1:0];
        end
    end

    // Sticky flag for an opcode that is not a return; set wins over clear.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            bad_q <= 1'b0;
        end else if (wr_instr && !new_valid) begin
            bad_q <= 1'b1;
        end else if (wr && (paddr == riu_pkg::OFS_STAT) && pwdata[riu_pkg::STAT_BAD_BIT]) begin
            bad_q <= 1'b0;
        end
    end

    // Global enables: an interrupt return sets one of the two, nothing else.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            irq_en_q <= riu_pkg::RST_BYTE;
        end else if (pop && is_irq_ret) begin
            if (ctrl_q[riu_pkg::CTRL_PRIO_BIT] && ctrl_q[riu_pkg::CTRL_LOWSVC_BIT]) begin
                irq_en_q[riu_pkg::IE_LOW_BIT] <= 1'b1;
            end else begin
                irq_en_q[riu_pkg::IE_HIGH_BIT] <= 1'b1;
            end
        end else if (wr && (paddr == riu_pkg::OFS_IRQ_EN)) begin
            irq_en_q <= pwdata[7:0];
        end
    end

    // Accumulator: literal or shadow on a return, else a bus write.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            acc_q <= riu_pkg::RST_BYTE;
        end else if (pop && is_lit_ret) begin
            acc_q <= literal;
        end else if (restore) begin
            acc_q <= acc_sh_q;
        end else if (wr && (paddr == riu_pkg::OFS_ACC)) begin
            acc_q <= pwdata[7:0];
        end
    end

    // Flags: only the shadow restore may change them during a return.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            flags_q <= riu_pkg::RST_BYTE;
        end else if (restore) begin
            flags_q <= flags_sh_q;
        end else if (wr && (paddr == riu_pkg::OFS_FLAGS)) begin
            flags_q <= pwdata[7:0];
        end
    end

    // Bank select.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            bank_q <= riu_pkg::RST_BYTE[riu_pkg::BANK_W-1:0];
        end else if (restore) begin
            bank_q <= bank_sh_q;
        end else if (wr && (paddr == riu_pkg::OFS_BANK)) begin
            bank_q <= pwdata[riu_pkg::BANK_W-1:0];
        end
    end

    // Shadow copies, loaded by software or by interrupt entry logic elsewhere.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            acc_sh_q <= riu_pkg::RST_BYTE;
            flags_sh_q <= riu_pkg::RST_BYTE;
            bank_sh_q <= riu_pkg::RST_BYTE[riu_pkg::BANK_W-1:0];
        end else if (wr) begin
            if (paddr == riu_pkg::OFS_ACC_SH) begin
                acc_sh_q <= pwdata[7:0];
            end else if (paddr == riu_pkg::OFS_FLAGS_SH) begin
                flags_sh_q <= pwdata[7:0];
            end else if (paddr == riu_pkg::OFS_BANK_SH) begin
                bank_sh_q <= pwdata[riu_pkg::BANK_W-1:0];
            end
        end
    end

    // Top of stack presented by the stack keeper.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            top_of_stack_q <= riu_pkg::RST_PC;
        end else if (wr && (paddr == riu_pkg::OFS_TOP_OF_STACK)) begin
            top_of_stack_q <= pwdata[riu_pkg::PC_W-1:0];
        end
    end

    // Program counter: every return loads it from the top of stack.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pc_q <= riu_pkg::RST_PC;
        end else if (pop) begin
            pc_q <= top_of_stack_q;
        end else if (wr && (paddr == riu_pkg::OFS_PC)) begin
            pc_q <= pwdata[riu_pkg::PC_W-1:0];
        end
    end

    // Address latches: returns never touch them.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pc_high_q <= riu_pkg::RST_BYTE;
            pc_upper_q <= riu_pkg::RST_BYTE;
        end else if (wr && (paddr == riu_pkg::OFS_PC_HIGH)) begin
            pc_high_q <= pwdata[7:0];
        end else if (wr && (paddr == riu_pkg::OFS_PC_UPPER)) begin
            pc_upper_q <= pwdata[7:0];
        end
    end

    // Read data is captured in the setup cycle and held for the access cycle.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rdata_q <= '0;
        end else if (psel && !penable && !pwrite) begin
            rdata_q <= '0;
            if (paddr == riu_pkg::OFS_INSTR) begin
                rdata_q[15:0] <= instr_q;
            end else if (paddr == riu_pkg::OFS_CTRL) begin
                rdata_q[1:0] <= ctrl_q;
            end else if (paddr == riu_pkg::OFS_IRQ_EN) begin
                rdata_q[7:0] <= irq_en_q;
            end else if (paddr == riu_pkg::OFS_ACC) begin
                rdata_q[7:0] <= acc_q;
            end else if (paddr == riu_pkg::OFS_FLAGS) begin
                rdata_q[7:0] <= flags_q;
            end else if (paddr == riu_pkg::OFS_BANK) begin
                rdata_q[riu_pkg::BANK_W-1:0] <= bank_q;
            end else if (paddr == riu_pkg::OFS_ACC_SH) begin
                rdata_q[7:0] <= acc_sh_q;
            end else if (paddr == riu_pkg::OFS_FLAGS_SH) begin
                rdata_q[7:0] <= flags_sh_q;
            end else if (paddr == riu_pkg::OFS_BANK_SH) begin
                rdata_q[riu_pkg::BANK_W-1:0] <= bank_sh_q;
            end else if (paddr == riu_pkg::OFS_TOP_OF_STACK) begin
                rdata_q[riu_pkg::PC_W-1:0] <= top_of_stack_q;
            end else if (paddr == riu_pkg::OFS_PC) begin
                rdata_q[riu_pkg::PC_W-1:0] <= pc_q;
            end else if (paddr == riu_pkg::OFS_PC_HIGH) begin
                rdata_q[7:0] <= pc_high_q;
            end else if (paddr == riu_pkg::OFS_PC_UPPER) begin
                rdata_q[7:0] <= pc_upper_q;
            end else if (paddr == riu_pkg::OFS_STAT) begin
                rdata_q[riu_pkg::STAT_BUSY_BIT] <= busy;
                rdata_q[riu_pkg::STAT_BAD_BIT] <= bad_q;
                rdata_q[5:4] <= quarter;
            end
        end
    end

    assign prdata = rdata_q;
    assign stack_pop_o = pop;
    assign pc_o = pc_q;
    assign busy_o = busy;

    // Each return stands for two instruction cycles of four quarters.
    two_cycle_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        start |=> busy_o [*8] ##1 !busy_o)
        else $error("Return did not last two instruction cycles.");

    // The pop falls in the fourth quarter of the first cycle.
    pop_time_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        start |-> !stack_pop_o [*4] ##1 stack_pop_o ##1 !stack_pop_o [*4])
        else $error("Stack pop came at the wrong quarter.");

    // The PC takes the top of stack right after the pop.
    pc_load_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        stack_pop_o |=> pc_o == $past(top_of_stack_q))
        else $error("PC not loaded from top of stack.");

    // An interrupt return turns on the chosen global enable.
    irq_set_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        stack_pop_o && is_irq_ret |=>
        (irq_en_q[riu_pkg::IE_HIGH_BIT] || irq_en_q[riu_pkg::IE_LOW_BIT]))
        else $error("Interrupt return left enables clear.");

    // Only the two enable bits may change on an interrupt return.
    irq_only_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        stack_pop_o |=> irq_en_q[5:0] == $past(irq_en_q[5:0]))
        else $error("Return disturbed other enable bits.");

    // Select one copies all three shadows.
    shadow_load_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        stack_pop_o && shadow_sel && !is_lit_ret |=>
        acc_q == $past(acc_sh_q) && flags_q == $past(flags_sh_q) && bank_q == $past(bank_sh_q))
        else $error("Shadow restore missing.");

    // Select zero leaves flags and bank as they were.
    no_shadow_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        stack_pop_o && !shadow_sel && !wr |=>
        $stable(flags_q) && $stable(bank_q))
        else $error("Registers changed without select.");

    // The literal lands in the accumulator.
    literal_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        stack_pop_o && is_lit_ret |=> acc_q == $past(instr_q[7:0]))
        else $error("Literal not written to accumulator.");

    // Address latches hold across a return.
    latch_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        stack_pop_o && !wr |=> $stable(pc_high_q) && $stable(pc_upper_q))
        else $error("Address latch changed by return.");

    // A subroutine return leaves the global enables alone.
    sub_enable_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        stack_pop_o && is_return && !wr |=> $stable(irq_en_q))
        else $error("Subroutine return changed enables.");

    // A literal return changes no flags, bank or enables.
    lit_keep_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        stack_pop_o && is_lit_ret && !wr |=>
        $stable(flags_q) && $stable(bank_q) && $stable(irq_en_q))
        else $error("Literal return changed other state.");

endmodule : riu_top

// [tb_top.sv]
// Purpose: Self-checking bench for the return instruction unit, driven over APB.
// Assumes: Zero-wait APB slave; a return keeps busy_o high for eight clocks.
// Notes: Ordinary returns come from a row table; awkward cases follow it.
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    typedef struct packed {
        logic [15:0] op;
        logic [1:0] ctrl;
        logic [20:0] top;
        logic [7:0] acc;
        logic [7:0] flg;
        logic [3:0] bank;
        logic [7:0] ie;
    } riu_row_type;

    logic clk_i;
    logic rst_n_i;
    logic psel;
    logic penable;
    logic pwrite;
    logic [riu_pkg::ADDR_W-1:0] paddr;
    logic [riu_pkg::DATA_W-1:0] pwdata;
    logic [riu_pkg::DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
    logic stack_pop_o;
    logic [riu_pkg::PC_W-1:0] pc_o;
    logic busy_o;
    int errors;
    int num_checks;
    riu_row_type rows [9];
    logic [31:0] rdat;
    logic err;
    logic [31:0] miss [4] = '{32'h0014, 32'h0110, 32'h0018, 32'h0D01};

    riu_top uut (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .stack_pop_o(stack_pop_o),
        .pc_o(pc_o),
        .busy_o(busy_o)
    );

    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    // Prints the verdict and ends the run.
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : tally_and_finish

    // Compares one result word.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One APB transfer; waits an edge first so signals are never set twice in a step.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        @(posedge clk_i);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) begin
            errors++;
            tally_and_finish();
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        logic e;
        apb(1'b0, a, 32'h0, r, e);
    endtask : rd

    // Waits until the unit is idle again, within a bound.
    task automatic wait_idle();
        int n;
        n = 0;
        while (busy_o !== 1'b0 && n < 40) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 40) begin
            errors++;
            tally_and_finish();
        end
    endtask : wait_idle

    // Runs one opcode and checks busy length and the single pop position.
    task automatic run(input logic [15:0] op);
        int nb;
        int npop;
        int pop_at;
        nb = 0;
        npop = 0;
        pop_at = 0;
        wr(riu_pkg::OFS_INSTR, {16'h0, op});
        for (int i = 0; i < 20; i++) begin
            @(posedge clk_i);
            if (busy_o === 1'b1) nb++;
            if (stack_pop_o === 1'b1) begin
                npop++;
                pop_at = nb;
            end
        end
        chk(nb, 8);
        chk(npop, 1);
        chk(pop_at, 4);
    endtask : run

    // Loads the core state that every row starts from.
    task automatic preset(input logic [1:0] ctrl, input logic [20:0] top);
        wr(riu_pkg::OFS_ACC, 32'h5A);
        wr(riu_pkg::OFS_FLAGS, 32'h33);
        wr(riu_pkg::OFS_BANK, 32'h2);
        wr(riu_pkg::OFS_ACC_SH, 32'hA5);
        wr(riu_pkg::OFS_FLAGS_SH, 32'hC3);
        wr(riu_pkg::OFS_BANK_SH, 32'h9);
        wr(riu_pkg::OFS_TOP_OF_STACK, {11'h0, top});
        wr(riu_pkg::OFS_PC_HIGH, 32'h12);
        wr(riu_pkg::OFS_PC_UPPER, 32'h34);
        wr(riu_pkg::OFS_IRQ_EN, 32'h0);
        wr(riu_pkg::OFS_CTRL, {30'h0, ctrl});
    endtask : preset

    initial begin
        #1000000;
        errors++;
        tally_and_finish();
    end

    initial begin
        errors = 0;
        num_checks = 0;
        rst_n_i = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        rows[0] = '{16'h0010, 2'h0, 21'h1ABCDE, 8'h5A, 8'h33, 4'h2, 8'h80};
        rows[1] = '{16'h0011, 2'h0, 21'h000002, 8'hA5, 8'hC3, 4'h9, 8'h80};
        rows[2] = '{16'h0010, 2'h3, 21'h1FFFFE, 8'h5A, 8'h33, 4'h2, 8'h40};
        rows[3] = '{16'h0011, 2'h1, 21'h0F0F0E, 8'hA5, 8'hC3, 4'h9, 8'h80};
        rows[4] = '{16'h0012, 2'h3, 21'h123456, 8'h5A, 8'h33, 4'h2, 8'h00};
        rows[5] = '{16'h0013, 2'h0, 21'h054320, 8'hA5, 8'hC3, 4'h9, 8'h00};
        rows[6] = '{16'h0C00, 2'h0, 21'h000100, 8'h00, 8'h33, 4'h2, 8'h00};
        rows[7] = '{16'h0CFF, 2'h3, 21'h1FFFFF, 8'hFF, 8'h33, 4'h2, 8'h00};
        rows[8] = '{16'h0C7E, 2'h2, 21'h0A0A0A, 8'h7E, 8'h33, 4'h2, 8'h00};
        repeat (10) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        for (int a = 0; a <= 'h34; a += 4) begin
            rd(8'(a), rdat);
            chk(rdat, 32'h0);
        end
        for (int i = 0; i < 9; i++) begin
            preset(rows[i].ctrl, rows[i].top);
            run(rows[i].op);
            chk({11'h0, pc_o}, {11'h0, rows[i].top});
            rd(riu_pkg::OFS_PC, rdat);
            chk(rdat, {11'h0, rows[i].top});
            rd(riu_pkg::OFS_ACC, rdat);
            chk(rdat, {24'h0, rows[i].acc});
            rd(riu_pkg::OFS_FLAGS, rdat);
            chk(rdat, {24'h0, rows[i].flg});
            rd(riu_pkg::OFS_BANK, rdat);
            chk(rdat, {28'h0, rows[i].bank});
            rd(riu_pkg::OFS_IRQ_EN, rdat);
            chk(rdat, {24'h0, rows[i].ie});
            rd(riu_pkg::OFS_PC_HIGH, rdat);
            chk(rdat, 32'h12);
            rd(riu_pkg::OFS_PC_UPPER, rdat);
            chk(rdat, 32'h34);
        end
        // A second opcode written while busy is refused and leaves the accumulator.
        preset(2'h0, 21'h0ABCDE);
        wr(riu_pkg::OFS_INSTR, 32'h0012);
        apb(1'b1, riu_pkg::OFS_INSTR, 32'h0C55, rdat, err);
        chk({31'h0, err}, 32'h1);
        wait_idle();
        rd(riu_pkg::OFS_ACC, rdat);
        chk(rdat, 32'h5A);
        chk({11'h0, pc_o}, 32'h0ABCDE);
        // Near-miss opcodes are not taken as returns.
        for (int k = 0; k < 4; k++) begin
            apb(1'b1, riu_pkg::OFS_INSTR, miss[k], rdat, err);
            chk({31'h0, err}, 32'h0);
            @(posedge clk_i);
            chk({31'h0, busy_o}, 32'h0);
            rd(riu_pkg::OFS_STAT, rdat);
            chk(rdat, 32'h2);
            wr(riu_pkg::OFS_STAT, 32'h2);
            rd(riu_pkg::OFS_STAT, rdat);
            chk(rdat, 32'h0);
        end
        // An unmapped address is refused and reads zero.
        apb(1'b0, 8'h38, 32'h0, rdat, err);
        chk({31'h0, err}, 32'h1);
        chk(rdat, 32'h0);
        // Reset in the middle of a return clears the sequencer and the counter.
        wr(riu_pkg::OFS_INSTR, 32'h0013);
        @(posedge clk_i);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        chk({30'h0, busy_o, stack_pop_o}, 32'h0);
        chk({11'h0, pc_o}, 32'h0);
        tally_and_finish();
    end
endmodule : tb_top
